/* hdl/adsl_loop.sv */
// How it works
// [R1] adc shifts 12-bit result msb first
// [R2] master holds select over two bytes
// [R3] output changes rising, sampled falling
// [R4] falling clock with select high releases data
// [R5] master holds adc frame sync high
// [R6] master shifts captured value right four
// [R7] master pulses dac frame sync
// [R8] dac word msb first, control then data
// [R9] output tri-state until select falls
// [R10] sampling spans 12 clocks after fourth fall
// [R11] select low all 16 clocks
// [R12] conversion after 16th fall, 28 clocks
// [R13] dac frame-sync fall starts 16-bit shift
// [R14] speed bit fast mode, powerdown bit off
// [R15] master masks twelve bits, adds fast pattern
// [R16] master sends dummy zero bytes
// [R17] no configuration, pins alone drive it
// [R18] master clock 1.25 MHz from 10 MHz
// [R19] master toggles dac frame sync per word
// [R20] master waits each byte before changes
`timescale 1ns/1ns
module adsl_loop
    import adsl_pkg::*;
(
    // clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RESETN_IN,
    // serial link
    input  wire logic                 SCLK_IN,
    input  wire logic                 ADC_CS_N_IN,
    input  wire logic                 FRAME_SYNC_PULSE_IN,
    output logic                      SERIAL_RESULT_OUT,
    output logic                      SERIAL_RESULT_OE_OUT,
    input  wire logic                 DAC_CS_N_IN,
    input  wire logic                 DAC_FRAME_SYNC_PULSE_IN,
    input  wire logic                 DAC_DIN_IN,
    // adc analog side
    input  wire logic [ADC_BITS-1:0]  SAMPLE_DATA_IN,
    output logic                      SAMPLING_OUT,
    output logic                      CONV_BUSY_OUT,
    // dac side
    output logic [WORD_BITS-1:0]      DAC_WORD_OUT,
    output logic                      DAC_WORD_VALID_OUT,
    input  wire logic                 DAC_WORD_READY_IN,
    output logic                      SPEED_SELECT_BIT_OUT,
    output logic                      POWERDOWN_BIT_OUT,
    output logic                      DAC_SETTLED_OUT
);
    // ----------------------------------------------------------------
    // synchronisers and edges
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] pin;
    logic [SYNC_W-1:0] pin_d;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_low;
    logic              cs_fall;
    logic              dfs_fall;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            meta  <= SYNC_RESET;
            pin   <= SYNC_RESET;
            pin_d <= SYNC_RESET;
        end else begin
            meta  <= {DAC_DIN_IN, DAC_FRAME_SYNC_PULSE_IN, DAC_CS_N_IN,
                      FRAME_SYNC_PULSE_IN, ADC_CS_N_IN, SCLK_IN};
            pin   <= meta;
            pin_d <= pin;
        end
    end

    always_comb begin
        sclk_rise = pin[LN_SCLK] && !pin_d[LN_SCLK];
        sclk_fall = !pin[LN_SCLK] && pin_d[LN_SCLK];
        // frame sync held high selects select-driven framing [R17]
        cs_low    = !pin[LN_ADC_CS] && pin[LN_ADC_FS];
        cs_fall   = cs_low && pin_d[LN_ADC_CS];
        dfs_fall  = !pin[LN_DAC_FS] && pin_d[LN_DAC_FS]
                    && !pin[LN_DAC_CS];
    end

    // ----------------------------------------------------------------
    // adc frame, sampling and conversion
    // ----------------------------------------------------------------
    logic [WORD_BITS-1:0] shift_reg;
    logic [4:0]           frame_cnt;
    logic                 seen_fall;
    logic [4:0]           conv_cnt;
    logic [ADC_BITS-1:0]  sample_hold;
    logic [ADC_BITS-1:0]  result;
    logic                 release_ok;
    logic [WORD_BITS-1:0] next_shift_reg;
    logic [4:0]           next_frame_cnt;
    logic                 next_seen_fall;
    logic [4:0]           next_conv_cnt;
    logic [ADC_BITS-1:0]  next_sample_hold;
    logic [ADC_BITS-1:0]  next_result;
    logic                 next_release_ok;
    logic                 next_oe;
    logic                 next_sampling;

    always_comb begin
        next_shift_reg   = shift_reg;
        next_frame_cnt   = frame_cnt;
        next_seen_fall   = seen_fall;
        next_conv_cnt    = conv_cnt;
        next_sample_hold = sample_hold;
        next_result      = result;
        next_release_ok  = release_ok;
        next_oe          = SERIAL_RESULT_OE_OUT;
        next_sampling    = SAMPLING_OUT;
        if (sclk_fall && conv_cnt != 5'h00) begin
            next_conv_cnt = conv_cnt - 5'h01; // [R12]
            if (conv_cnt == 5'h01) begin
                next_result = sample_hold; // [R12]
            end
        end
        if (cs_fall) begin
            next_oe        = 1'b1; // [R9]
            next_seen_fall = 1'b0;
            next_frame_cnt = 5'h00;
            if (release_ok) begin
                next_shift_reg  = {result, PAD_ZERO}; // [R1]
                next_release_ok = 1'b0;
            end
        end else if (!cs_low) begin
            next_oe       = 1'b0; // [R9]
            next_sampling = 1'b0; // [R11]
            if (sclk_fall) begin
                next_release_ok = 1'b1; // [R4]
            end
        end else begin
            if (sclk_rise && seen_fall) begin
                next_shift_reg = {shift_reg[WORD_BITS-2:0], 1'b0}; // [R3]
            end
            if (sclk_fall && frame_cnt != FRAME_FALLS) begin
                next_seen_fall = 1'b1;
                next_frame_cnt = frame_cnt + 5'h01;
                if (next_frame_cnt == SAMPLE_START_FALL) begin
                    next_sampling = 1'b1; // [R10]
                end
                if (next_frame_cnt == FRAME_FALLS) begin
                    next_sampling    = 1'b0; // [R11]
                    next_sample_hold = SAMPLE_DATA_IN; // [R10]
                    next_conv_cnt    = CONV_CYCLES; // [R12]
                end
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            shift_reg            <= '0;
            frame_cnt            <= 5'h00;
            seen_fall            <= 1'b0;
            conv_cnt             <= 5'h00;
            sample_hold          <= '0;
            result               <= '0;
            release_ok           <= 1'b0;
            SERIAL_RESULT_OE_OUT <= 1'b0;
            SERIAL_RESULT_OUT    <= 1'b0;
            SAMPLING_OUT         <= 1'b0;
            CONV_BUSY_OUT        <= 1'b0;
        end else begin
            shift_reg            <= next_shift_reg;
            frame_cnt            <= next_frame_cnt;
            seen_fall            <= next_seen_fall;
            conv_cnt             <= next_conv_cnt;
            sample_hold          <= next_sample_hold;
            result               <= next_result;
            release_ok           <= next_release_ok;
            SERIAL_RESULT_OE_OUT <= next_oe;
            SERIAL_RESULT_OUT    <= next_shift_reg[WORD_BITS-1]; // [R1]
            SAMPLING_OUT         <= next_sampling;
            CONV_BUSY_OUT        <= (next_conv_cnt != 5'h00);
        end
    end

    // ----------------------------------------------------------------
    // dac word receiver
    // ----------------------------------------------------------------
    adsl_dac_e            dac_state;
    adsl_dac_e            next_dac_state;
    logic [4:0]           bit_cnt;
    logic [4:0]           next_bit_cnt;
    logic [WORD_BITS-1:0] dac_shift;
    logic [WORD_BITS-1:0] next_dac_shift;
    logic                 push_valid;
    logic                 push_ready;
    logic                 next_speed;
    logic                 next_powerdown;
    logic [7:0]           settle_cnt;
    logic [7:0]           next_settle_cnt;

    always_comb begin
        next_dac_state  = dac_state;
        next_bit_cnt    = bit_cnt;
        next_dac_shift  = dac_shift;
        next_speed      = SPEED_SELECT_BIT_OUT;
        next_powerdown  = POWERDOWN_BIT_OUT;
        next_settle_cnt = (settle_cnt != 8'h00) ? settle_cnt - 8'h01
                                                : settle_cnt;
        push_valid      = 1'b0;
        unique case (dac_state)
            DAC_IDLE: begin
                if (dfs_fall) begin
                    next_dac_state = DAC_SHIFT; // [R13]
                    next_bit_cnt   = 5'h00;
                end
            end
            DAC_SHIFT: begin
                if (pin[LN_DAC_CS]) begin
                    next_dac_state = DAC_IDLE;
                end else if (sclk_fall) begin
                    next_dac_shift = {dac_shift[WORD_BITS-2:0],
                                      pin[LN_DAC_DIN]}; // [R8]
                    next_bit_cnt   = bit_cnt + 5'h01;
                    if (next_bit_cnt == DAC_WORD_FALLS) begin
                        next_dac_state = DAC_PUSH; // [R13]
                    end
                end
            end
            DAC_PUSH: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    next_dac_state  = DAC_IDLE;
                    next_speed      = dac_shift[SPEED_BIT_POS]; // [R14]
                    next_powerdown  = dac_shift[POWERDOWN_BIT_POS]; // [R14]
                    next_settle_cnt = dac_shift[SPEED_BIT_POS]
                                      ? FAST_CONV_CYC
                                      : SLOW_CONV_CYC; // [R14]
                end
            end
            default: next_dac_state = DAC_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dac_state            <= DAC_IDLE;
            bit_cnt              <= 5'h00;
            dac_shift            <= '0;
            settle_cnt           <= 8'h00;
            SPEED_SELECT_BIT_OUT <= 1'b0;
            POWERDOWN_BIT_OUT    <= 1'b0;
            DAC_SETTLED_OUT      <= 1'b1;
        end else begin
            dac_state            <= next_dac_state;
            bit_cnt              <= next_bit_cnt;
            dac_shift            <= next_dac_shift;
            settle_cnt           <= next_settle_cnt;
            SPEED_SELECT_BIT_OUT <= next_speed;
            POWERDOWN_BIT_OUT    <= next_powerdown;
            DAC_SETTLED_OUT      <= (next_settle_cnt == 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // received word buffer
    // ----------------------------------------------------------------
    adsl_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (MCLK_IN),
        .resetn_in     (RESETN_IN),
        .in_valid_in   (push_valid),
        .in_ready_out  (push_ready),
        .in_data_in    (dac_shift),
        .out_valid_out (DAC_WORD_VALID_OUT),
        .out_ready_in  (DAC_WORD_READY_IN),
        .out_data_out  (DAC_WORD_OUT)
    );
endmodule : adsl_loop

/* hdl/adsl_pkg.sv */
package adsl_pkg;
    // ----------------------------------------------------------------
    // converter geometry
    // ----------------------------------------------------------------
    localparam int          ADC_BITS          = 12;
    localparam int          WORD_BITS         = 16;
    localparam logic [3:0]  PAD_ZERO          = 4'h0;
    localparam logic [4:0]  SAMPLE_START_FALL = 5'h04;
    localparam logic [4:0]  FRAME_FALLS       = 5'h10;
    localparam logic [4:0]  CONV_CYCLES       = 5'h1c;
    localparam logic [4:0]  DAC_WORD_FALLS    = 5'h10;
    localparam int          SPEED_BIT_POS     = 14;
    localparam int          POWERDOWN_BIT_POS = 13;
    localparam int          FIFO_DEPTH        = 8;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          MCLK_PERIOD_NS    = 100;
    localparam int          FAST_CONV_NS      = 3000;
    localparam int          SLOW_CONV_NS      = 10000;
    localparam logic [7:0]  FAST_CONV_CYC     =
        8'(FAST_CONV_NS / MCLK_PERIOD_NS);
    localparam logic [7:0]  SLOW_CONV_CYC     =
        8'(SLOW_CONV_NS / MCLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // synchroniser lanes
    // ----------------------------------------------------------------
    localparam int          SYNC_W     = 6;
    localparam int          LN_SCLK    = 0;
    localparam int          LN_ADC_CS  = 1;
    localparam int          LN_ADC_FS  = 2;
    localparam int          LN_DAC_CS  = 3;
    localparam int          LN_DAC_FS  = 4;
    localparam int          LN_DAC_DIN = 5;
    localparam logic [5:0]  SYNC_RESET = 6'h1e;

    // ----------------------------------------------------------------
    // dac receive states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DAC_IDLE  = 2'b00,
        DAC_SHIFT = 2'b01,
        DAC_PUSH  = 2'b10
    } adsl_dac_e;
endpackage : adsl_pkg

/* hdl/adsl_fifo.sv */
`timescale 1ns/1ns
module adsl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    // ----------------------------------------------------------------
    // pointers and output stage
    // ----------------------------------------------------------------
    always_comb begin
        push           = in_valid_in && (count != (AW+1)'(DEPTH));
        pop            = (count != '0) && (!out_valid_out || out_ready_in);
        next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
        next_out_valid = out_valid_out;
        next_out_data  = out_data_out;
        if (pop) begin
            next_out_valid = 1'b1;
            next_out_data  = mem[rd_ptr];
        end else if (out_ready_in) begin
            next_out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr        <= '0;
            rd_ptr        <= '0;
            count         <= '0;
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
            in_ready_out  <= 1'b1;
        end else begin
            wr_ptr        <= next_wr_ptr;
            rd_ptr        <= next_rd_ptr;
            count         <= next_count;
            out_valid_out <= next_out_valid;
            out_data_out  <= next_out_data;
            in_ready_out  <= (next_count != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule : adsl_fifo

/* test/adsl_loop_chk.sv */
`timescale 1ns/1ns
module adsl_loop_chk
    import adsl_pkg::*;
(
    // clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RESETN_IN,
    // watched pins
    input  wire logic                 SCLK_IN,
    input  wire logic                 ADC_CS_N_IN,
    input  wire logic                 FRAME_SYNC_PULSE_IN,
    input  wire logic                 SERIAL_RESULT_OUT,
    input  wire logic                 SERIAL_RESULT_OE_OUT,
    input  wire logic                 SAMPLING_OUT,
    input  wire logic                 CONV_BUSY_OUT,
    input  wire logic [WORD_BITS-1:0] DAC_WORD_OUT,
    input  wire logic                 DAC_WORD_VALID_OUT,
    input  wire logic                 DAC_WORD_READY_IN,
    input  wire logic                 SPEED_SELECT_BIT_OUT,
    input  wire logic                 POWERDOWN_BIT_OUT,
    input  wire logic                 DAC_SETTLED_OUT
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    int   samp_cnt, next_samp_cnt, fall_cnt, next_fall_cnt;
    int   low_cnt, next_low_cnt;
    logic sclk_prev, next_sclk_prev;
    always_comb begin
        next_sclk_prev = SCLK_IN;
        next_samp_cnt  = SAMPLING_OUT ? samp_cnt + 1 :
                         (CONV_BUSY_OUT ? samp_cnt : 0);
        next_fall_cnt  = CONV_BUSY_OUT ?
                         fall_cnt + int'(sclk_prev && !SCLK_IN) : 0;
        next_low_cnt   = DAC_SETTLED_OUT ? 0 : low_cnt + 1;
    end
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sclk_prev <= 1'b0;
            samp_cnt  <= 0;
            fall_cnt  <= 0;
            low_cnt   <= 0;
        end else begin
            sclk_prev <= next_sclk_prev;
            samp_cnt  <= next_samp_cnt;
            fall_cnt  <= next_fall_cnt;
            low_cnt   <= next_low_cnt;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    a_oe_idle_low: assert property (
        ADC_CS_N_IN [*4] |-> !SERIAL_RESULT_OE_OUT)
        else $error("result driven while deselected");
    a_oe_on_select: assert property (
        ($fell(ADC_CS_N_IN) && FRAME_SYNC_PULSE_IN)
        |-> ##[1:4] SERIAL_RESULT_OE_OUT)
        else $error("result driver not enabled");
    a_oe_off_release: assert property (
        $rose(ADC_CS_N_IN) |-> ##[1:4] !SERIAL_RESULT_OE_OUT)
        else $error("result driver not released");
    a_bit_on_rise: assert property (
        (SERIAL_RESULT_OE_OUT && $past(SERIAL_RESULT_OE_OUT)
         && $changed(SERIAL_RESULT_OUT))
        |-> ($past(SCLK_IN, 2) || $past(SCLK_IN, 3) || $past(SCLK_IN, 4)))
        else $error("result bit changed away from a rise");
    a_sample_span: assert property (
        $rose(CONV_BUSY_OUT) |-> samp_cnt inside {[95:97]})
        else $error("sampling window not twelve clocks");
    a_conv_after_sample: assert property (
        $rose(CONV_BUSY_OUT) |-> $fell(SAMPLING_OUT))
        else $error("conversion not right after sampling");
    a_conv_length: assert property (
        $fell(CONV_BUSY_OUT) |-> fall_cnt == 28)
        else $error("conversion length wrong");
    a_ctrl_bits: assert property (
        $rose(DAC_WORD_VALID_OUT) |->
        SPEED_SELECT_BIT_OUT == DAC_WORD_OUT[SPEED_BIT_POS] &&
        POWERDOWN_BIT_OUT == DAC_WORD_OUT[POWERDOWN_BIT_POS])
        else $error("control bits do not follow word");
    a_settle_time: assert property (
        $rose(DAC_SETTLED_OUT) |->
        low_cnt == (SPEED_SELECT_BIT_OUT ? 30 : 100))
        else $error("settle time wrong for speed");
    a_word_holds: assert property (
        (DAC_WORD_VALID_OUT && !DAC_WORD_READY_IN) |=>
        DAC_WORD_VALID_OUT && $stable(DAC_WORD_OUT))
        else $error("word dropped while stalled");
endmodule : adsl_loop_chk

bind adsl_loop adsl_loop_chk i_chk (
    .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .SCLK_IN(SCLK_IN),
    .ADC_CS_N_IN(ADC_CS_N_IN), .FRAME_SYNC_PULSE_IN(FRAME_SYNC_PULSE_IN),
    .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
    .SERIAL_RESULT_OE_OUT(SERIAL_RESULT_OE_OUT),
    .SAMPLING_OUT(SAMPLING_OUT), .CONV_BUSY_OUT(CONV_BUSY_OUT),
    .DAC_WORD_OUT(DAC_WORD_OUT), .DAC_WORD_VALID_OUT(DAC_WORD_VALID_OUT),
    .DAC_WORD_READY_IN(DAC_WORD_READY_IN),
    .SPEED_SELECT_BIT_OUT(SPEED_SELECT_BIT_OUT),
    .POWERDOWN_BIT_OUT(POWERDOWN_BIT_OUT),
    .DAC_SETTLED_OUT(DAC_SETTLED_OUT));

/* test/adsl_master_model.sv */
`timescale 1ns/1ns
module adsl_master_model (
    // clock
    input  wire logic clk_in,
    // converter pins
    output logic      sclk_out,
    output logic      adc_cs_n_out,
    output logic      adc_fs_out,
    input  wire logic result_in,
    input  wire logic result_oe_in,
    output logic      dac_cs_n_out,
    output logic      dac_fs_out,
    output logic      dac_din_out
);
    logic last_bit;
    initial begin
        sclk_out     = 1'b0;
        adc_cs_n_out = 1'b1;
        adc_fs_out   = 1'b1;
        dac_cs_n_out = 1'b1;
        dac_fs_out   = 1'b1;
        dac_din_out  = 1'b0;
        last_bit     = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    // one serial clock: data out on rise, sample on fall
    task automatic clk_bit(input logic tx, output logic rx);
        step(4);
        sclk_out    = 1'b1;
        dac_din_out = tx;
        step(4);
        rx          = result_oe_in ? result_in : ~last_bit;
        last_bit    = rx;
        sclk_out    = 1'b0;
    endtask : clk_bit
    task automatic adc_read(input int n, output logic [15:0] rx);
        logic b;
        rx           = 16'h0000;
        adc_cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            clk_bit(1'b0, b);
            rx = {rx[14:0], b};
        end
        step(4);
        adc_cs_n_out = 1'b1;
    endtask : adc_read
    task automatic set_fs(input logic v);
        adc_fs_out = v;
    endtask : set_fs
    task automatic idle_clocks(input int n);
        logic b;
        for (int i = 0; i < n; i++) clk_bit(1'b0, b);
    endtask : idle_clocks
    task automatic dac_write(input logic [15:0] w);
        logic b;
        dac_cs_n_out = 1'b0;
        step(2);
        dac_fs_out   = 1'b0;
        for (int i = 15; i >= 0; i--) clk_bit(w[i], b);
        step(4);
        dac_fs_out   = 1'b1;
        dac_cs_n_out = 1'b1;
        dac_din_out  = ~dac_din_out;
        step(2);
    endtask : dac_write
endmodule : adsl_master_model

/* test/adsl_loop_tb.sv */
`timescale 1ns/1ns
module adsl_loop_tb
    import adsl_pkg::*;
    ;
    logic        mclk, resetn, sclk, adc_cs_n, adc_fs, result, result_oe;
    logic        dac_cs_n, dac_fs, dac_din, sampling, busy, valid, ready;
    logic        speed, pdown, settled;
    logic [11:0] sample;
    logic [15:0] word, last_rx;
    int          n_mismatch, checks_done;
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    adsl_master_model i_master (.clk_in(mclk), .sclk_out(sclk),
        .adc_cs_n_out(adc_cs_n), .adc_fs_out(adc_fs), .result_in(result),
        .result_oe_in(result_oe), .dac_cs_n_out(dac_cs_n),
        .dac_fs_out(dac_fs), .dac_din_out(dac_din));
    adsl_loop i_dut (.MCLK_IN(mclk), .RESETN_IN(resetn), .SCLK_IN(sclk),
        .ADC_CS_N_IN(adc_cs_n), .FRAME_SYNC_PULSE_IN(adc_fs),
        .SERIAL_RESULT_OUT(result), .SERIAL_RESULT_OE_OUT(result_oe),
        .DAC_CS_N_IN(dac_cs_n), .DAC_FRAME_SYNC_PULSE_IN(dac_fs),
        .DAC_DIN_IN(dac_din), .SAMPLE_DATA_IN(sample),
        .SAMPLING_OUT(sampling), .CONV_BUSY_OUT(busy),
        .DAC_WORD_OUT(word), .DAC_WORD_VALID_OUT(valid),
        .DAC_WORD_READY_IN(ready), .SPEED_SELECT_BIT_OUT(speed),
        .POWERDOWN_BIT_OUT(pdown), .DAC_SETTLED_OUT(settled));
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic pop(input logic [15:0] exp);
        int k;
        k = 0;
        while (valid !== 1'b1 && k < 20) begin
            i_master.step(1);
            k++;
        end
        check({15'h0, valid}, 16'h0001, "word valid");
        check(word, exp, "dac word");
        ready = 1'b1;
        i_master.step(1);
        ready = 1'b0;
        i_master.step(1);
    endtask : pop
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_adc_loop();
        logic [15:0] rx;
        sample = 12'ha5c;
        i_master.adc_read(16, rx);
        check(rx, 16'h0000, "first frame");
        i_master.idle_clocks(32);
        sample = 12'h3c7;
        i_master.adc_read(16, rx);
        check(rx, 16'ha5c0, "result msb first");
        i_master.idle_clocks(32);
        sample = 12'h5a1;
        i_master.adc_read(16, rx);
        check(rx, 16'h3c70, "next result");
        last_rx = rx;
        i_master.idle_clocks(32);
        $display("test adc_loop done");
    endtask : t_adc_loop
    task automatic t_abort();
        logic [15:0] rx;
        sample = 12'h111;
        i_master.adc_read(8, rx);
        i_master.idle_clocks(4);
        check({15'h0, busy}, 16'h0000, "no conversion");
        i_master.idle_clocks(28);
        i_master.adc_read(16, rx);
        check(rx, 16'h5a10, "result kept");
        i_master.idle_clocks(32);
        $display("test abort done");
    endtask : t_abort
    task automatic t_no_frame();
        logic [15:0] rx;
        sample = 12'h222;
        i_master.set_fs(1'b0);
        i_master.adc_read(16, rx);
        i_master.idle_clocks(4);
        check({15'h0, busy}, 16'h0000, "fs low frame");
        i_master.set_fs(1'b1);
        i_master.adc_read(16, rx);
        check(rx, 16'h1110, "result after fs low");
        i_master.idle_clocks(32);
        $display("test no_frame done");
    endtask : t_no_frame
    task automatic t_dac_words();
        logic [15:0] w [4];
        w = '{16'h4000 | {4'h0, last_rx[15:4]}, 16'h2123, 16'h6abc,
              16'h0fff};
        foreach (w[i]) begin
            i_master.dac_write(w[i]);
            check({14'h0, speed, pdown}, {14'h0, w[i][14:13]}, "ctrl");
            pop(w[i]);
        end
        $display("test dac_words done");
    endtask : t_dac_words
    task automatic t_fifo();
        for (int i = 0; i < 10; i++) i_master.dac_write(16'h4000 | 16'(i));
        for (int i = 0; i < 10; i++) pop(16'h4000 | 16'(i));
        i_master.step(3);
        check({15'h0, valid}, 16'h0000, "fifo empty");
        $display("test fifo done");
    endtask : t_fifo
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_mismatch  = 0;
        checks_done = 0;
        resetn      = 1'b0;
        sample      = 12'h000;
        ready       = 1'b0;
        last_rx     = 16'h0000;
        repeat (6) @(posedge mclk);
        #1;
        check({11'h0, result_oe, valid, busy, sampling, settled},
              16'h0001, "reset values");
        resetn = 1'b1;
        i_master.step(4);
        t_adc_loop();
        t_abort();
        t_no_frame();
        t_dac_words();
        t_fifo();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        wrap_up();
    end
endmodule : adsl_loop_tb
